// [shared/ddsr_pkg.sv]
// Purpose: constants of the distributed transfer slave register front end
// Assumes: 32-bit host bus data, byte enables, one channel
// Notes: register offsets are dword numbers inside the 16-byte window
package ddsr_pkg;
  // ********************************************************
  // window and configuration
  // ********************************************************
  localparam logic [7:0] CFG_BASE_OFS = 8'h98;
  localparam int WIN_BITS = 4;
  localparam logic [1:0] DW_ADDR = 2'h0;
  localparam logic [1:0] DW_COUNT = 2'h1;
  localparam logic [1:0] DW_CTRL = 2'h2;
  localparam logic [1:0] DW_MASK = 2'h3;
  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CMD_DISABLE_POS = 2;
  localparam int MODE_WIDE_POS = 0;
  localparam int MASK_POS = 0;
  // ********************************************************
  // reset values and count steps
  // ********************************************************
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [31:0] AD_RST = 32'h0000_0000;
  localparam logic [15:0] STEP_NARROW = 16'h0001;
  localparam logic [15:0] STEP_WIDE = 16'h0002;
endpackage

// [rtl/ddsr_buf.sv]
// Purpose: two-entry buffer for address-phase words
// Assumes: single clock, asynchronous active-low reset
// Notes: head and ready are flops so the top drives them straight
`timescale 1ns/1ps
`default_nettype none
module ddsr_buf #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output var logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output var logic out_valid_o,
  input wire logic out_ready_i,
  output var logic [W-1:0] out_data_o
);
  logic [W-1:0] slot1;
  logic pop;
  logic push;
  assign pop = out_valid_o & out_ready_i;
  assign push = in_valid_i & in_ready_o;

  // ********************************************************
  // head and spare slot
  // ********************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      in_ready_o <= 1'b1;
      out_data_o <= '0;
      slot1 <= '0;
    end else if (pop) begin
      if (!in_ready_o) begin
        out_data_o <= slot1;
        in_ready_o <= 1'b1;
      end else begin
        out_data_o <= in_data_i;
        out_valid_o <= push;
      end
    end else if (push) begin
      if (!out_valid_o) begin
        out_data_o <= in_data_i;
        out_valid_o <= 1'b1;
      end else begin
        slot1 <= in_data_i;
        in_ready_o <= 1'b0;
      end
    end
  end
endmodule // ddsr_buf
`default_nettype wire

// [rtl/ddsr_top.sv]
// Purpose: register front end of one distributed transfer slave channel
// Assumes: host bus I/O cycles arrive as one-cycle strobes, synchronous
// Notes: address-phase words pass a two-entry buffer toward the AD lines
// How it works
// - registers decoded in 16-byte window at config 98h
// - address/page 00h, count 04h, control 08h, mask 0Ch
// - unused legacy bits read-only, no function
// - reserved locations read zero, writes ignored
// - address write loads start address, resets zero
// - address read returns current address
// - 8-bit: address on AD15-0, page AD23-16
// - 16-bit: address shifted onto AD16-1
// - 16-bit: AD0 driven low
// - 16-bit: page 7-1 on AD23-17, bit0 ignored
// - count minus one narrow, minus two wide
// - terminal count sets flags; read or reset clears
// - disable bit zero means enabled, reset enabled
`timescale 1ns/1ps
`default_nettype none
module ddsr_top (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic CFG_WR_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic IO_RD_I,
  input wire logic IO_WR_I,
  input wire logic [31:0] IO_ADDR_I,
  input wire logic [3:0] IO_BE_I,
  input wire logic [31:0] IO_WDATA_I,
  output logic [31:0] IO_RDATA_O,
  output logic IO_ACK_O,
  input wire logic CARD_DREQ_I,
  input wire logic XFER_START_I,
  input wire logic XFER_DONE_I,
  output logic [31:0] AD_O,
  output logic AD_VALID_O,
  input wire logic AD_READY_I,
  output logic XFER_READY_O,
  output logic CTRL_DISABLED_O,
  output logic SW_REQ_O,
  output logic MASK_O,
  output logic TERM_COUNT_O
);
  logic [31:0] base;
  logic [15:0] cur_addr;
  logic [15:0] count;
  logic [7:0] page;
  logic [7:0] mode;
  logic [3:0] terminal_count_flags;
  logic controller_disable_bit;
  logic wide;
  logic [15:0] step;
  logic tc_event;
  logic rd_hit;
  logic wr_hit;
  logic [1:0] dw;
  logic master_clear;
  logic status_read;
  logic push;
  logic [31:0] push_data;

  // a base of zero keeps the window shut until configuration sets one
  function automatic logic in_window(input logic [31:0] a, input logic [31:0] b);
    in_window = (b != ddsr_pkg::BASE_RST) && (a[31:ddsr_pkg::WIN_BITS] == b[31:ddsr_pkg::WIN_BITS]);
  endfunction

  // 16-bit words address word positions, so the page loses bit 0
  function automatic logic [31:0] ad_word(input logic [15:0] a, input logic [7:0] p, input logic w);
    ad_word = w ? {8'h00, p[7:1], a, 1'b0} : {8'h00, p, a};
  endfunction

  // ********************************************************
  // decode
  // ********************************************************
  assign dw = IO_ADDR_I[3:2];
  assign rd_hit = IO_RD_I & in_window(IO_ADDR_I, base);
  assign wr_hit = IO_WR_I & in_window(IO_ADDR_I, base);
  assign master_clear = wr_hit & (dw == ddsr_pkg::DW_MASK) & IO_BE_I[1];
  assign status_read = rd_hit & (dw == ddsr_pkg::DW_CTRL) & IO_BE_I[0];
  assign wide = mode[ddsr_pkg::MODE_WIDE_POS];
  assign step = wide ? ddsr_pkg::STEP_WIDE : ddsr_pkg::STEP_NARROW;
  assign tc_event = XFER_DONE_I & (count <= step);
  assign push = XFER_START_I & ~controller_disable_bit & XFER_READY_O;
  assign push_data = ad_word(cur_addr, page, wide);
  assign CTRL_DISABLED_O = controller_disable_bit;
  assign TERM_COUNT_O = terminal_count_flags[0];

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      base <= ddsr_pkg::BASE_RST;
    end else if (CFG_WR_I && CFG_ADDR_I == ddsr_pkg::CFG_BASE_OFS) begin
      base <= {CFG_WDATA_I[31:ddsr_pkg::WIN_BITS], 4'h0};
    end
  end

  // ********************************************************
  // address, page, count
  // ********************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cur_addr <= ddsr_pkg::ADDR_RST;
      page <= ddsr_pkg::PAGE_RST;
    end else if (master_clear) begin
      cur_addr <= ddsr_pkg::ADDR_RST;
      page <= ddsr_pkg::PAGE_RST;
    end else if (wr_hit && dw == ddsr_pkg::DW_ADDR) begin
      if (IO_BE_I[0]) cur_addr[7:0] <= IO_WDATA_I[7:0];
      if (IO_BE_I[1]) cur_addr[15:8] <= IO_WDATA_I[15:8];
      if (IO_BE_I[2]) page <= IO_WDATA_I[23:16];
    end else if (XFER_DONE_I) begin
      cur_addr <= cur_addr + 16'h0001;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      count <= ddsr_pkg::COUNT_RST;
    end else if (master_clear) begin
      count <= ddsr_pkg::COUNT_RST;
    end else if (wr_hit && dw == ddsr_pkg::DW_COUNT) begin
      if (IO_BE_I[0]) count[7:0] <= IO_WDATA_I[7:0];
      if (IO_BE_I[1]) count[15:8] <= IO_WDATA_I[15:8];
    end else if (XFER_DONE_I) begin
      count <= count - step;
    end
  end

  // ********************************************************
  // command, mode, request, mask, status
  // ********************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      controller_disable_bit <= 1'b0;
      mode <= ddsr_pkg::MODE_RST;
      SW_REQ_O <= 1'b0;
      MASK_O <= 1'b1;
    end else if (master_clear) begin
      controller_disable_bit <= 1'b0;
      mode <= ddsr_pkg::MODE_RST;
      SW_REQ_O <= 1'b0;
      MASK_O <= 1'b1;
    end else begin
      if (wr_hit && dw == ddsr_pkg::DW_CTRL) begin
        // of byte 0 only the disable bit stores; the rest of that byte is dropped
        if (IO_BE_I[0]) controller_disable_bit <= IO_WDATA_I[ddsr_pkg::CMD_DISABLE_POS];
        if (IO_BE_I[1]) SW_REQ_O <= 1'b1;
        if (IO_BE_I[3]) mode <= IO_WDATA_I[31:24];
      end
      if (wr_hit && dw == ddsr_pkg::DW_MASK && IO_BE_I[3]) begin
        MASK_O <= IO_WDATA_I[24 + ddsr_pkg::MASK_POS];
      end
    end
  end

  // a terminal count in the read cycle survives the clear
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      terminal_count_flags <= 4'h0;
    end else if (tc_event) begin
      terminal_count_flags <= 4'hF;
    end else if (status_read || master_clear) begin
      terminal_count_flags <= 4'h0;
    end
  end

  // ********************************************************
  // read answer
  // ********************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      IO_RDATA_O <= 32'h0000_0000;
      IO_ACK_O <= 1'b0;
    end else begin
      IO_ACK_O <= rd_hit | wr_hit;
      if (rd_hit) begin
        case (dw)
          ddsr_pkg::DW_ADDR: IO_RDATA_O <= {8'h00, page, cur_addr};
          ddsr_pkg::DW_COUNT: IO_RDATA_O <= {16'h0000, count};
          ddsr_pkg::DW_CTRL: IO_RDATA_O <= {24'h00_0000, {4{CARD_DREQ_I}}, terminal_count_flags};
          ddsr_pkg::DW_MASK: IO_RDATA_O <= {7'h00, MASK_O, 24'h00_0000};
          default: IO_RDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  ddsr_buf #(.W(32)) u_buf (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .in_valid_i(push),
    .in_ready_o(XFER_READY_O),
    .in_data_i(push_data),
    .out_valid_o(AD_VALID_O),
    .out_ready_i(AD_READY_I),
    .out_data_o(AD_O)
  );

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  window_ack_a: assert property (IO_ACK_O |-> $past(rd_hit | wr_hit)) else $error("ack outside window");
  count_read_a: assert property (rd_hit && dw == ddsr_pkg::DW_COUNT |=> IO_RDATA_O == {16'h0000, $past(count)})
    else $error("count read wrong");
  ctrl_zero_a: assert property (rd_hit && dw == ddsr_pkg::DW_CTRL |=> IO_RDATA_O[31:8] == 24'h00_0000)
    else $error("control upper bytes not zero");
  addr_load_a: assert property (wr_hit && dw == ddsr_pkg::DW_ADDR && IO_BE_I[1:0] == 2'h3 && !master_clear
    |=> cur_addr == $past(IO_WDATA_I[15:0])) else $error("address not loaded");
  addr_read_a: assert property (rd_hit && dw == ddsr_pkg::DW_ADDR |=> IO_RDATA_O[15:0] == $past(cur_addr))
    else $error("address read not current");
  narrow_ad_a: assert property (push && !AD_VALID_O && !wide |=> AD_O[23:0] == {$past(page), $past(cur_addr)})
    else $error("narrow address phase wrong");
  wide_ad_a: assert property (push && !AD_VALID_O && wide |=> AD_O[16:1] == $past(cur_addr) && !AD_O[0])
    else $error("wide address phase wrong");
  wide_page_a: assert property (push && !AD_VALID_O && wide |=> AD_O[23:17] == $past(page[7:1]))
    else $error("wide page wrong");
  count_step_a: assert property (XFER_DONE_I && !wr_hit |=> count == $past(count) - (wide ? 16'h0002 : 16'h0001))
    else $error("count step wrong");
  tc_set_a: assert property (tc_event |=> terminal_count_flags == 4'hF ##1 1'b1)
    else $error("terminal count not set");
  tc_clear_a: assert property (status_read && !tc_event |=> terminal_count_flags == 4'h0)
    else $error("terminal count not cleared");
  disabled_a: assert property (controller_disable_bit && !AD_VALID_O |=> !AD_VALID_O)
    else $error("word issued while disabled");
  addr_step_a: assert property (XFER_DONE_I && !wr_hit |=> cur_addr == $past(cur_addr) + 16'h0001)
    else $error("address not advanced");

  narrow_xfer_c: cover property (push && !wide ##1 AD_VALID_O);
  wide_xfer_c: cover property (push && wide);
  tc_seen_c: cover property (tc_event ##[1:8] status_read);
  buf_full_c: cover property (!XFER_READY_O && XFER_START_I);
endmodule // ddsr_top
`default_nettype wire

// [testbench/ddsr_host_model.sv]
// Purpose: far-side consumer of address-phase words
// Assumes: one clock, active-low asynchronous reset
// Notes: slow mode takes a word only every other cycle
`timescale 1ns/1ps
`default_nettype none
module ddsr_host_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output var logic ad_ready_o
);
  logic phase;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end
  // slow mode keeps a word held in the buffer for up to one extra cycle
  assign ad_ready_o = reset_n_i && !stall_i && (!slow_i || phase);
endmodule // ddsr_host_model
`default_nettype wire

// [testbench/tb.sv]
// Purpose: self-checking bench of the transfer slave register front end
// Assumes: strobes driven at the falling edge, seed fixed
// Notes: address-phase words checked against a queue of expected words
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK_I, RESET_N_I, CFG_WR_I, IO_RD_I, IO_WR_I, CARD_DREQ_I, XFER_START_I, XFER_DONE_I;
  logic [7:0] CFG_ADDR_I, pg;
  logic [31:0] CFG_WDATA_I, IO_ADDR_I, IO_WDATA_I, IO_RDATA_O, AD_O, rd;
  logic [3:0] IO_BE_I;
  logic IO_ACK_O, AD_VALID_O, AD_READY_I, XFER_READY_O, CTRL_DISABLED_O, SW_REQ_O, MASK_O, TERM_COUNT_O;
  logic stall, slow, ack;
  logic [15:0] a, c;
  logic [31:0] exp_q[$];
  int mismatches, n_tests, n;
  localparam logic [31:0] BASE = 32'h0000_1230;
  ddsr_top u_dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CFG_WR_I(CFG_WR_I), .CFG_ADDR_I(CFG_ADDR_I),
    .CFG_WDATA_I(CFG_WDATA_I), .IO_RD_I(IO_RD_I), .IO_WR_I(IO_WR_I), .IO_ADDR_I(IO_ADDR_I), .IO_BE_I(IO_BE_I),
    .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O), .IO_ACK_O(IO_ACK_O), .CARD_DREQ_I(CARD_DREQ_I),
    .XFER_START_I(XFER_START_I), .XFER_DONE_I(XFER_DONE_I), .AD_O(AD_O), .AD_VALID_O(AD_VALID_O),
    .AD_READY_I(AD_READY_I), .XFER_READY_O(XFER_READY_O), .CTRL_DISABLED_O(CTRL_DISABLED_O),
    .SW_REQ_O(SW_REQ_O), .MASK_O(MASK_O), .TERM_COUNT_O(TERM_COUNT_O));
  ddsr_host_model u_host (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .stall_i(stall), .slow_i(slow),
    .ad_ready_o(AD_READY_I));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] ad_word(logic wide, logic [7:0] p, logic [15:0] adr);
    return wide ? {8'h00, p[7:1], adr, 1'b0} : {8'h00, p, adr};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic io(input logic wr, input logic [31:0] adr, input logic [3:0] be, input logic [31:0] d,
                    input logic exp_ack);
    @(negedge CLK_I);
    {IO_WR_I, IO_RD_I, IO_ADDR_I, IO_BE_I, IO_WDATA_I} = {wr, !wr, adr, be, d};
    ack = 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(negedge CLK_I);
      if (i == 0) {IO_WR_I, IO_RD_I} = 2'b00;
      if (!ack && IO_ACK_O === 1'b1) {ack, rd} = {1'b1, IO_RDATA_O};
    end
    chk({31'h0, ack}, {31'h0, exp_ack});
  endtask
  task automatic pulse(ref logic s);
    @(negedge CLK_I);
    s = 1'b1;
    @(negedge CLK_I);
    s = 1'b0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end
  always @(negedge CLK_I) begin
    #1;
    if (RESET_N_I && AD_VALID_O === 1'b1 && AD_READY_I === 1'b1) begin
      chk(AD_O, exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF);
    end
  end
  initial begin
    repeat (20000) @(posedge CLK_I);
    mismatches++;
    complete_run();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {RESET_N_I, CFG_WR_I, IO_RD_I, IO_WR_I, CARD_DREQ_I, XFER_START_I, XFER_DONE_I, stall, slow} = 9'h0;
    {CFG_ADDR_I, CFG_WDATA_I, IO_ADDR_I, IO_BE_I, IO_WDATA_I} = '0;
    void'($urandom(32'h78E0));
    repeat (12) @(negedge CLK_I);
    chk({25'h0, XFER_READY_O, MASK_O, AD_VALID_O, TERM_COUNT_O, CTRL_DISABLED_O, SW_REQ_O, IO_ACK_O},
        32'h0000_0060);
    RESET_N_I = 1'b1;
    io(1'b0, BASE, 4'hF, 32'h0, 1'b0);
    @(negedge CLK_I);
    {CFG_WR_I, CFG_ADDR_I, CFG_WDATA_I} = {1'b1, 8'h98, BASE};
    @(negedge CLK_I);
    CFG_WR_I = 1'b0;
    io(1'b0, BASE, 4'hF, 32'h0, 1'b1);
    chk(rd, 32'h0);
    io(1'b0, BASE + 32'h10, 4'hF, 32'h0, 1'b0);
    a = 16'($urandom);
    pg = 8'($urandom);
    c = 16'h0100 + 16'($urandom % 256);
    io(1'b1, BASE, 4'h7, {8'h0, pg, a}, 1'b1);
    io(1'b1, BASE + 4, 4'h3, {16'h0, c}, 1'b1);
    io(1'b1, BASE + 4, 4'hC, 32'hFFFF_0000, 1'b1);
    io(1'b0, BASE + 4, 4'hF, 32'h0, 1'b1);
    chk(rd, {16'h0, c});
    io(1'b1, BASE + 12, 4'h1, 32'hFF, 1'b1);
    io(1'b0, BASE + 12, 4'hF, 32'h0, 1'b1);
    chk(rd, 32'h0100_0000);
    for (int w = 0; w < 2; w++) begin
      io(1'b1, BASE + 8, 4'h8, {7'h0, w[0], 24'h0}, 1'b1);
      n = 1 + $urandom % 3;
      exp_q.push_back(ad_word(w[0], pg, a));
      pulse(XFER_START_I);
      repeat (n) pulse(XFER_DONE_I);
      a = a + 16'(n);
      c = c - 16'(n * (w + 1));
      exp_q.push_back(ad_word(w[0], pg, a));
      pulse(XFER_START_I);
      io(1'b0, BASE, 4'hF, 32'h0, 1'b1);
      chk(rd, {8'h0, pg, a});
      io(1'b0, BASE + 4, 4'hF, 32'h0, 1'b1);
      chk(rd, {16'h0, c});
      chk(32'(exp_q.size()), 32'h0);
    end
    CARD_DREQ_I = 1'b1;
    for (int w = 0; w < 2; w++) begin
      io(1'b1, BASE + 8, 4'h8, {7'h0, w[0], 24'h0}, 1'b1);
      io(1'b1, BASE + 4, 4'h3, 32'h2, 1'b1);
      if (w == 0) pulse(XFER_DONE_I);
      chk({31'h0, TERM_COUNT_O}, 32'h0);
      pulse(XFER_DONE_I);
      chk({31'h0, TERM_COUNT_O}, 32'h1);
      io(1'b0, BASE + 8, 4'h1, 32'h0, 1'b1);
      chk(rd, 32'hFF);
      io(1'b0, BASE + 8, 4'h1, 32'h0, 1'b1);
      chk(rd, 32'hF0);
    end
    io(1'b1, BASE + 8, 4'h9, 32'h4, 1'b1);
    chk({31'h0, CTRL_DISABLED_O}, 32'h1);
    pulse(XFER_START_I);
    repeat (3) @(negedge CLK_I);
    chk({31'h0, AD_VALID_O}, 32'h0);
    io(1'b1, BASE + 8, 4'h1, 32'h0, 1'b1);
    chk({31'h0, CTRL_DISABLED_O}, 32'h0);
    stall = 1'b1;
    for (int k = 0; k < 3; k++) begin
      a = 16'($urandom);
      io(1'b1, BASE, 4'h3, {16'h0, a}, 1'b1);
      if (k < 2) exp_q.push_back(ad_word(1'b0, pg, a));
      pulse(XFER_START_I);
    end
    chk({31'h0, XFER_READY_O}, 32'h0);
    {stall, slow} = 2'b01;
    repeat (10) @(negedge CLK_I);
    chk({31'h0, XFER_READY_O}, 32'h1);
    chk(32'(exp_q.size()), 32'h0);
    io(1'b1, BASE + 8, 4'h2, 32'h0, 1'b1);
    io(1'b1, BASE + 12, 4'h8, 32'h0, 1'b1);
    chk({30'h0, SW_REQ_O, MASK_O}, 32'h2);
    io(1'b1, BASE + 12, 4'h2, 32'h0, 1'b1);
    io(1'b0, BASE, 4'hF, 32'h0, 1'b1);
    chk(rd, 32'h0);
    chk({30'h0, SW_REQ_O, MASK_O}, 32'h1);
    complete_run();
  end
endmodule // tb
`default_nettype wire
